/* ead_decode.sv */
// Effective address and operand decode for a 16-bit instruction word.
// Assumes the pipeline presents the register values that belong to the
// instruction in the request cycle; results appear one cycle later.
`timescale 1ns/1ps

// What this block does
// - Direct mode: register itself is operand
// - Indirect: address is destination register value
// - Post-increment: use value, then add 1/2/4
// - Pre-decrement: subtract 1/2/4, write back, use
// - Zero-extended 4-bit offset scaled plus register
// - Zero-extended 8-bit offset scaled plus global base
// - Indexed global base: base plus register zero
// - Counter-relative load: offset times 2/4 plus counter
// - Longword counter load clears two low bits
// - Short branch: sign-extend 8 bits, double, add
// - Long branch: sign-extend 12 bits, double, add
// - Register branch: register plus program counter
// - Logic and test literals zero-extend to 32
// - Move, add, compare literals sign-extend
// - Trap literal zero-extended times four
// - Destination bits 11..8, source bits 7..4
// - Multiply-accumulate: both pointers post-incremented, accumulator result
// - Offset format: base 7..4, offset 3..0
// - Literal in bits 7..0, opcode above
// - Misaligned word or longword data address raises address error, except the second MAC pointer
module ead_decode (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [15:0] instr,
    input wire ead_pkg::ead_mode_t mode,
    input wire ead_pkg::ead_size_t size,
    input wire logic [31:0] dest_val,
    input wire logic [31:0] src_val,
    input wire logic [31:0] zero_val,
    input wire logic [31:0] gbr_val,
    input wire logic [31:0] pc_val,
    output logic rsp_valid,
    output logic [3:0] dest_num,
    output logic [3:0] src_num,
    output logic [31:0] addr,
    output logic mem_access,
    output logic is_branch,
    output logic [31:0] opnd,
    output logic opnd_valid,
    output logic wb_en,
    output logic [3:0] wb_num,
    output logic [31:0] wb_val,
    output logic wb2_en,
    output logic [3:0] wb2_num,
    output logic [31:0] wb2_val,
    output logic acc_pair,
    output logic addr_err
);
    import ead_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Field extraction
    logic [3:0] dst_f;
    logic [3:0] src_f;
    logic [3:0] d4_f;
    logic [7:0] lit_f;
    logic [11:0] d12_f;
    logic [31:0] step_w;
    logic [31:0] d4_sc;
    logic [31:0] d8_sc;

    assign dst_f = instr[EAD_DST_MSB:EAD_DST_LSB];
    assign src_f = instr[EAD_SRC_MSB:EAD_SRC_LSB];
    assign d4_f = instr[EAD_D4_MSB:EAD_D4_LSB];
    assign lit_f = instr[EAD_LIT_MSB:EAD_LIT_LSB];
    assign d12_f = instr[EAD_D12_MSB:EAD_D12_LSB];

    // Size in bytes: 1, 2 or 4
    assign step_w = 32'h0000_0001 << size;

    ead_scale #(
        .W(EAD_D4_W)
    ) u_scale4 (
        .disp(d4_f),
        .size(size),
        .scaled(d4_sc)
    );

    ead_scale #(
        .W(EAD_D8_W)
    ) u_scale8 (
        .disp(lit_f),
        .size(size),
        .scaled(d8_sc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state decode
    logic [31:0] addr_d;
    logic mem_d;
    logic br_d;
    logic [31:0] opnd_d;
    logic opnd_v_d;
    logic wb_en_d;
    logic [3:0] wb_num_d;
    logic [31:0] wb_val_d;
    logic wb2_en_d;
    logic [31:0] wb2_val_d;
    logic acc_d;
    logic err_d;

    always_comb begin
        addr_d = EAD_WORD_RST;
        mem_d = 1'b0;
        br_d = 1'b0;
        opnd_d = EAD_WORD_RST;
        opnd_v_d = 1'b0;
        wb_en_d = 1'b0;
        wb_num_d = EAD_NUM_RST;
        wb_val_d = EAD_WORD_RST;
        wb2_en_d = 1'b0;
        wb2_val_d = EAD_WORD_RST;
        acc_d = 1'b0;
        case (mode)
            EAD_M_DIRECT: begin
                opnd_d = dest_val;
                opnd_v_d = 1'b1;
            end
            EAD_M_INDIR: begin
                addr_d = dest_val;
                mem_d = 1'b1;
            end
            EAD_M_POSTINC: begin
                addr_d = src_val;
                mem_d = 1'b1;
                wb_en_d = 1'b1;
                wb_num_d = src_f;
                wb_val_d = src_val + step_w;
            end
            EAD_M_PREDEC: begin
                addr_d = dest_val - step_w;
                mem_d = 1'b1;
                wb_en_d = 1'b1;
                wb_num_d = dst_f;
                wb_val_d = dest_val - step_w;
            end
            EAD_M_DISP4: begin
                addr_d = src_val + d4_sc;
                mem_d = 1'b1;
            end
            EAD_M_IDXREG: begin
                addr_d = dest_val + zero_val;
                mem_d = 1'b1;
            end
            EAD_M_GBRDISP: begin
                addr_d = gbr_val + d8_sc;
                mem_d = 1'b1;
            end
            EAD_M_GBRIDX: begin
                addr_d = gbr_val + zero_val;
                mem_d = 1'b1;
            end
            EAD_M_PCDISP: begin
                mem_d = 1'b1;
                if (size == EAD_SZ_LONG) begin
                    addr_d = (pc_val & EAD_PC_LONG_MASK) + d8_sc;
                end else begin
                    addr_d = pc_val + {23'h00_0000, lit_f, 1'b0};
                end
            end
            EAD_M_BR8: begin
                addr_d = pc_val + {{23{lit_f[7]}}, lit_f, 1'b0};
                br_d = 1'b1;
            end
            EAD_M_BR12: begin
                addr_d = pc_val + {{19{d12_f[11]}}, d12_f, 1'b0};
                br_d = 1'b1;
            end
            EAD_M_BRREG: begin
                addr_d = pc_val + dest_val;
                br_d = 1'b1;
            end
            EAD_M_IMMZX: begin
                opnd_d = {24'h00_0000, lit_f};
                opnd_v_d = 1'b1;
            end
            EAD_M_IMMSX: begin
                opnd_d = {{24{lit_f[7]}}, lit_f};
                opnd_v_d = 1'b1;
            end
            EAD_M_TRAP: begin
                opnd_d = {22'h00_0000, lit_f, 2'b00};
                opnd_v_d = 1'b1;
            end
            EAD_M_MAC: begin
                // Two post-incremented pointers, result to accumulator pair
                addr_d = src_val;
                mem_d = 1'b1;
                wb_en_d = 1'b1;
                wb_num_d = src_f;
                wb_val_d = src_val + step_w;
                wb2_en_d = 1'b1;
                wb2_val_d = dest_val + step_w;
                acc_d = 1'b1;
            end
            default: begin
                mem_d = 1'b0;
            end
        endcase
        // Alignment is checked on the first data address only
        case (size)
            EAD_SZ_WORD: err_d = mem_d & addr_d[0];
            EAD_SZ_LONG: err_d = mem_d & (|addr_d[1:0]);
            default: err_d = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
        end
    end

    // Register numbers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dest_num <= EAD_NUM_RST;
            src_num <= EAD_NUM_RST;
        end else if (req_valid) begin
            dest_num <= dst_f;
            src_num <= src_f;
        end
    end

    // Address group
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr <= EAD_WORD_RST;
            mem_access <= 1'b0;
            is_branch <= 1'b0;
            addr_err <= 1'b0;
        end else begin
            addr <= req_valid ? addr_d : addr;
            mem_access <= req_valid & mem_d;
            is_branch <= req_valid & br_d;
            addr_err <= req_valid & err_d;
        end
    end

    // Operand group
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            opnd <= EAD_WORD_RST;
            opnd_valid <= 1'b0;
        end else begin
            opnd <= req_valid ? opnd_d : opnd;
            opnd_valid <= req_valid & opnd_v_d;
        end
    end

    // Register write-back group
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_en <= 1'b0;
            wb_num <= EAD_NUM_RST;
            wb_val <= EAD_WORD_RST;
            wb2_en <= 1'b0;
            wb2_num <= EAD_NUM_RST;
            wb2_val <= EAD_WORD_RST;
            acc_pair <= 1'b0;
        end else begin
            wb_en <= req_valid & wb_en_d;
            wb2_en <= req_valid & wb2_en_d;
            acc_pair <= req_valid & acc_d;
            if (req_valid) begin
                wb_num <= wb_num_d;
                wb_val <= wb_val_d;
                wb2_num <= dst_f;
                wb2_val <= wb2_val_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_req(ead_mode_t m);
        req_valid && mode == m;
    endsequence

    sequence s_req_sz(ead_mode_t m, ead_size_t s);
        req_valid && mode == m && size == s;
    endsequence

    property p_direct;
        s_req(EAD_M_DIRECT) |=> opnd == $past(dest_val) && opnd_valid && !mem_access;
    endproperty
    a_direct: assert property (p_direct) else $error("direct operand wrong");

    property p_indir;
        s_req(EAD_M_INDIR) |=> addr == $past(dest_val) && mem_access && !wb_en;
    endproperty
    a_indir: assert property (p_indir) else $error("indirect address wrong");

    property p_postinc;
        s_req_sz(EAD_M_POSTINC, EAD_SZ_LONG) |=>
            addr == $past(src_val) && wb_en && wb_val == addr + 32'h0000_0004;
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment wrong");

    property p_predec;
        s_req_sz(EAD_M_PREDEC, EAD_SZ_WORD) |=>
            wb_en && addr == $past(dest_val) - 32'h0000_0002 && wb_val == addr;
    endproperty
    a_predec: assert property (p_predec) else $error("pre-decrement wrong");

    property p_disp4;
        s_req_sz(EAD_M_DISP4, EAD_SZ_LONG) |=>
            addr == $past(src_val) + {26'h000_0000, $past(instr[3:0]), 2'b00};
    endproperty
    a_disp4: assert property (p_disp4) else $error("4-bit offset address wrong");

    property p_gbrdisp;
        s_req_sz(EAD_M_GBRDISP, EAD_SZ_WORD) |=>
            addr == $past(gbr_val) + {23'h00_0000, $past(instr[7:0]), 1'b0};
    endproperty
    a_gbrdisp: assert property (p_gbrdisp) else $error("global base offset wrong");

    property p_gbridx;
        s_req(EAD_M_GBRIDX) |=> addr == $past(gbr_val) + $past(zero_val);
    endproperty
    a_gbridx: assert property (p_gbridx) else $error("indexed global base wrong");

    property p_pclong;
        s_req_sz(EAD_M_PCDISP, EAD_SZ_LONG) |=> addr[1:0] == 2'b00 &&
            addr == {$past(pc_val[31:2]), 2'b00} + {22'h00_0000, $past(instr[7:0]), 2'b00};
    endproperty
    a_pclong: assert property (p_pclong) else $error("counter load address wrong");

    property p_br8;
        s_req(EAD_M_BR8) |=> is_branch &&
            addr == $past(pc_val) + {{23{$past(instr[7])}}, $past(instr[7:0]), 1'b0};
    endproperty
    a_br8: assert property (p_br8) else $error("short branch target wrong");

    property p_br12;
        s_req(EAD_M_BR12) |=> is_branch &&
            addr == $past(pc_val) + {{19{$past(instr[11])}}, $past(instr[11:0]), 1'b0};
    endproperty
    a_br12: assert property (p_br12) else $error("long branch target wrong");

    property p_imm;
        s_req(EAD_M_IMMSX) |=> opnd[31:8] == {24{opnd[7]}} && opnd[7:0] == $past(instr[7:0]);
    endproperty
    a_imm: assert property (p_imm) else $error("signed literal wrong");

    property p_trap;
        s_req(EAD_M_TRAP) |=> opnd == {22'h00_0000, $past(instr[7:0]), 2'b00};
    endproperty
    a_trap: assert property (p_trap) else $error("trap offset wrong");

    property p_mac;
        s_req(EAD_M_MAC) |=> acc_pair && wb_en && wb2_en && wb2_num == $past(instr[11:8]) &&
            wb2_val == $past(dest_val) + (32'h0000_0001 << $past(size));
    endproperty
    a_mac: assert property (p_mac) else $error("accumulate pointers wrong");

    property p_align;
        rsp_valid && mem_access && !acc_pair ##0 (addr[0] && !$past(size == EAD_SZ_BYTE))
            |-> addr_err;
    endproperty
    a_align: assert property (p_align) else $error("address error missed");

endmodule // ead_decode

/* ead_pipe_model.sv */
// Model of the fetch and execute pipeline's register file beside the decoder.
// Assumes the decoder's write-back strobes last one cycle; they are bypassed.
`timescale 1ns/1ps
module ead_pipe_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] instr,
    input wire logic wb_en,
    input wire logic [3:0] wb_num,
    input wire logic [31:0] wb_val,
    input wire logic wb2_en,
    input wire logic [3:0] wb2_num,
    input wire logic [31:0] wb2_val,
    output logic [31:0] dest_val,
    output logic [31:0] src_val,
    output logic [31:0] zero_val
);
    logic [31:0] regs_q [16];

    ////////////////////////////////////////////////////////////
    // Register reads with bypass of pending write-backs
    always_comb begin
        dest_val = regs_q[instr[11:8]];
        src_val = regs_q[instr[7:4]];
        zero_val = regs_q[0];
        if (wb_en && wb_num == instr[11:8]) dest_val = wb_val;
        if (wb_en && wb_num == instr[7:4]) src_val = wb_val;
        if (wb_en && wb_num == 4'h0) zero_val = wb_val;
        if (wb2_en && wb2_num == instr[11:8]) dest_val = wb2_val;
        if (wb2_en && wb2_num == instr[7:4]) src_val = wb2_val;
        if (wb2_en && wb2_num == 4'h0) zero_val = wb2_val;
    end

    // Write-back after execution; second pointer applied last
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) regs_q[i] <= 32'h0101_0104 * 32'(i);
        end else begin
            if (wb_en) regs_q[wb_num] <= wb_val;
            if (wb2_en) regs_q[wb2_num] <= wb2_val;
        end
    end
endmodule // ead_pipe_model

/* ead_pkg.sv */
// Package for the effective address decoder: field positions, masks,
// access sizes and addressing modes.
// Assumes a 16-bit instruction word and 32-bit registers.
package ead_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction field positions
    localparam int EAD_DST_MSB = 11;
    localparam int EAD_DST_LSB = 8;
    localparam int EAD_SRC_MSB = 7;
    localparam int EAD_SRC_LSB = 4;
    localparam int EAD_D4_MSB = 3;
    localparam int EAD_D4_LSB = 0;
    localparam int EAD_LIT_MSB = 7;
    localparam int EAD_LIT_LSB = 0;
    localparam int EAD_D12_MSB = 11;
    localparam int EAD_D12_LSB = 0;
    localparam int EAD_D4_W = 4;
    localparam int EAD_D8_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Masks and reset values
    localparam logic [31:0] EAD_PC_LONG_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] EAD_WORD_RST = 32'h0000_0000;
    localparam logic [3:0] EAD_NUM_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Access size; the code is also the scale shift
    typedef enum logic [1:0] {
        EAD_SZ_BYTE = 2'h0,
        EAD_SZ_WORD = 2'h1,
        EAD_SZ_LONG = 2'h2
    } ead_size_t;

    // Addressing modes, one-hot
    typedef enum logic [15:0] {
        EAD_M_DIRECT = 16'h0001,
        EAD_M_INDIR = 16'h0002,
        EAD_M_POSTINC = 16'h0004,
        EAD_M_PREDEC = 16'h0008,
        EAD_M_DISP4 = 16'h0010,
        EAD_M_IDXREG = 16'h0020,
        EAD_M_GBRDISP = 16'h0040,
        EAD_M_GBRIDX = 16'h0080,
        EAD_M_PCDISP = 16'h0100,
        EAD_M_BR8 = 16'h0200,
        EAD_M_BR12 = 16'h0400,
        EAD_M_BRREG = 16'h0800,
        EAD_M_IMMZX = 16'h1000,
        EAD_M_IMMSX = 16'h2000,
        EAD_M_TRAP = 16'h4000,
        EAD_M_MAC = 16'h8000
    } ead_mode_t;

endpackage

/* ead_scale.sv */
// Zero-extends a displacement field and scales it by access size.
// Assumes the size code equals the left shift (0, 1 or 2).
`timescale 1ns/1ps
module ead_scale #(
    parameter int W = 4
) (
    input wire logic [W-1:0] disp,
    input wire ead_pkg::ead_size_t size,
    output logic [31:0] scaled
);
    import ead_pkg::*;

    logic [31:0] zext_w;

    assign zext_w = {{(32 - W){1'b0}}, disp};

    always_comb begin
        case (size)
            EAD_SZ_WORD: scaled = {zext_w[30:0], 1'b0};
            EAD_SZ_LONG: scaled = {zext_w[29:0], 2'b00};
            default: scaled = zext_w;
        endcase
    end

endmodule // ead_scale

/* effective_address_decode_tb.sv */
// Self-checking bench for the effective address decoder.
// Assumes ead_pkg, ead_decode and ead_pipe_model are compiled first.
`timescale 1ns/1ps
module effective_address_decode_tb;
    import ead_pkg::*;
    typedef struct packed {
        logic [3:0] dn;
        logic [3:0] sn;
        logic [31:0] a;
        logic mem;
        logic br;
        logic [31:0] op;
        logic ov;
        logic wb;
        logic [3:0] wn;
        logic [31:0] wv;
        logic wb2;
        logic [3:0] w2n;
        logic [31:0] w2v;
        logic acc;
        logic err;
    } ead_exp_t;
    logic ref_clk, rst_n, req_valid, rsp_valid, mem_access, is_branch, opnd_valid;
    logic wb_en, wb2_en, acc_pair, addr_err, taken;
    logic [15:0] instr, seed_q;
    ead_mode_t mode;
    ead_size_t size;
    logic [31:0] dest_val, src_val, zero_val, gbr_val, pc_val, addr, opnd, wb_val, wb2_val;
    logic [3:0] dest_num, src_num, wb_num, wb2_num;
    logic [31:0] mir [16];
    ead_exp_t exp_q [$];
    ead_exp_t mon_e;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    ead_decode uut (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .instr(instr),
        .mode(mode), .size(size), .dest_val(dest_val), .src_val(src_val),
        .zero_val(zero_val), .gbr_val(gbr_val), .pc_val(pc_val), .rsp_valid(rsp_valid),
        .dest_num(dest_num), .src_num(src_num), .addr(addr), .mem_access(mem_access),
        .is_branch(is_branch), .opnd(opnd), .opnd_valid(opnd_valid), .wb_en(wb_en),
        .wb_num(wb_num), .wb_val(wb_val), .wb2_en(wb2_en), .wb2_num(wb2_num),
        .wb2_val(wb2_val), .acc_pair(acc_pair), .addr_err(addr_err));
    ead_pipe_model pipe (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .wb_en(wb_en),
        .wb_num(wb_num), .wb_val(wb_val), .wb2_en(wb2_en), .wb2_num(wb2_num),
        .wb2_val(wb2_val), .dest_val(dest_val), .src_val(src_val), .zero_val(zero_val));

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [15:0] next_rnd();
        seed_q = {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
        return seed_q;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic reset_mirror();
        for (int i = 0; i < 16; i++) mir[i] = 32'h0101_0104 * 32'(i);
    endtask

    ////////////////////////////////////////////////////////////
    // Stimulus: expectation is noted when the request is driven
    task automatic issue(input int k);
        ead_exp_t e;
        logic [15:0] w;
        logic [31:0] d, s, z, g, p, st, l8;
        ead_size_t sz;
        w = next_rnd();
        g = {next_rnd(), next_rnd()};
        p = {next_rnd(), next_rnd()};
        sz = ead_size_t'(2'(next_rnd() % 16'h0003));
        d = mir[w[11:8]];
        s = mir[w[7:4]];
        z = mir[0];
        st = 32'h0000_0001 << sz;
        l8 = {24'h00_0000, w[7:0]};
        e = '0;
        e.dn = w[11:8];
        e.sn = w[7:4];
        case (k)
            0: e.op = d;
            1: e.a = d;
            2: {e.a, e.wb, e.wn, e.wv} = {s, 1'b1, w[7:4], s + st};
            3: {e.a, e.wb, e.wn, e.wv} = {d - st, 1'b1, w[11:8], d - st};
            4: e.a = s + ({28'h000_0000, w[3:0]} << sz);
            5: e.a = d + z;
            6: e.a = g + (l8 << sz);
            7: e.a = g + z;
            8: e.a = sz == EAD_SZ_LONG ? (p & EAD_PC_LONG_MASK) + (l8 << 2) : p + (l8 << 1);
            9: e.a = p + {{23{w[7]}}, w[7:0], 1'b0};
            10: e.a = p + {{19{w[11]}}, w[11:0], 1'b0};
            11: e.a = p + d;
            12: e.op = l8;
            13: e.op = {{24{w[7]}}, w[7:0]};
            14: e.op = {22'h00_0000, w[7:0], 2'h0};
            15: begin
                {e.a, e.wb, e.wn, e.wv} = {s, 1'b1, w[7:4], s + st};
                {e.wb2, e.w2n, e.w2v, e.acc} = {1'b1, w[11:8], d + st, 1'b1};
            end
            default: ;
        endcase
        e.ov = (k == 0 || (k >= 12 && k <= 14));
        e.mem = (k >= 1 && k <= 8) || k == 15;
        e.br = (k >= 9 && k <= 11);
        e.err = e.mem && ((sz == EAD_SZ_WORD && e.a[0]) || (sz == EAD_SZ_LONG && e.a[1:0] != 0));
        if (e.wb) mir[e.wn] = e.wv;
        if (e.wb2) mir[e.w2n] = e.w2v;
        exp_q.push_back(e);
        req_valid <= 1'b1;
        instr <= w;
        mode <= ead_mode_t'(k == 16 ? 16'h0000 : 16'h0001 << k);
        size <= sz;
        gbr_val <= g;
        pc_val <= p;
    endtask

    task automatic run(input int count);
        for (int n = 0; n < count; n++) begin
            @(posedge ref_clk);
            if (next_rnd() % 16'h0004 == 16'h0000) req_valid <= 1'b0;
            else issue(n % 17);
        end
        @(posedge ref_clk);
        req_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////
    // Monitor: answer one cycle after each taken request
    always @(posedge ref_clk) begin
        taken <= rst_n & req_valid;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    always @(negedge ref_clk) begin
        check({31'h0, rsp_valid}, {31'h0, taken});
        if (rsp_valid !== 1'b1) begin
            check({25'h0, mem_access, is_branch, opnd_valid, wb_en, wb2_en, acc_pair, addr_err},
                32'h0);
        end else if (exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            check({28'h0, dest_num}, {28'h0, mon_e.dn});
            check({28'h0, src_num}, {28'h0, mon_e.sn});
            check({25'h0, mem_access, is_branch, opnd_valid, wb_en, wb2_en, acc_pair, addr_err},
                {25'h0, mon_e.mem, mon_e.br, mon_e.ov, mon_e.wb, mon_e.wb2, mon_e.acc,
                mon_e.err});
            if (mon_e.mem | mon_e.br) check(addr, mon_e.a);
            if (mon_e.ov) check(opnd, mon_e.op);
            if (mon_e.wb) check({28'h0, wb_num}, {28'h0, mon_e.wn});
            if (mon_e.wb) check(wb_val, mon_e.wv);
            if (mon_e.wb2) check({28'h0, wb2_num}, {28'h0, mon_e.w2n});
            if (mon_e.wb2) check(wb2_val, mon_e.w2v);
        end
    end

    initial begin
        seed_q = 16'hF468;
        rst_n = 1'b0;
        req_valid = 1'b0;
        instr = 16'h0000;
        mode = ead_mode_t'(16'h0000);
        size = EAD_SZ_BYTE;
        gbr_val = 32'h0000_0000;
        pc_val = 32'h0000_0000;
        reset_mirror();
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        run(400);
        rst_n <= 1'b0;
        reset_mirror();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check(addr, 32'h0000_0000);
        check(opnd, 32'h0000_0000);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        run(60);
        check(exp_q.size(), 32'h0000_0000);
        finish_test();
    end
endmodule // effective_address_decode_tb
